// ### verilog/lcf_pkg.sv
// constants, register map and state type of the segment display frame controller
package lcf_pkg;
    // ==========================================================
    // register byte offsets on the apb bus
    localparam logic [11:0] ADDR_CTRL = 12'h000; // display_main_control
    localparam logic [11:0] ADDR_PS = 12'h004; // frame_prescale_waveform
    localparam logic [11:0] ADDR_REG = 12'h008; // bias_regulator_control
    localparam logic [11:0] ADDR_FLAG = 12'h00c; // peripheral_flag_reg_three
    localparam logic [11:0] ADDR_IEN = 12'h010; // peripheral_enable_reg_three
    localparam logic [11:0] ADDR_SE_BASE = 12'h020; // segment_pin_enable_00_07 .. _32
    localparam logic [11:0] ADDR_PIX_BASE = 12'h040; // pixel_com0_seg00_07 first
    localparam logic [4:0] NUM_SE = 5'h05; // segment enable bytes
    localparam logic [4:0] NUM_PIX = 5'h14; // pixel bytes, five per common
    localparam logic [4:0] PIX_PER_COM = 5'h05; // bytes per common line
    // ==========================================================
    // field positions
    localparam int CTRL_EN = 7; // module_enable
    localparam int CTRL_SLEEP_STOP_ENABLE = 6; // sleep_stop_enable
    localparam int CTRL_WRITE_ERROR_FLAG = 5; // write_error_flag
    localparam int CTRL_CS_LSB = 2; // timing source select
    localparam int CTRL_MUX_LSB = 0; // common_count_select
    localparam logic [7:0] CTRL_WMASK = 8'hcf; // bits stored directly
    localparam int PS_WFT = 7; // waveform_type_select
    localparam int PS_BIAS_MODE_SELECT = 6; // bias_mode_select
    localparam int PS_ACTIVE = 5; // module_active_status
    localparam int PS_WA = 4; // write_allowed_status
    localparam logic [7:0] PS_WMASK = 8'hcf; // bits stored directly
    localparam int REG_CHARGE_PUMP_ENABLE = 6; // charge_pump_enable
    localparam int REG_BIAS_LSB = 3; // bias level field
    localparam int REG_REGULATOR_BIAS_MODE = 2; // regulator_bias_mode
    localparam int REG_CKSEL_LSB = 0; // regulator_clock_select
    localparam logic [7:0] REG_WMASK = 8'h7f; // bit 7 unimplemented
    localparam int FLAG_BIT = 6; // frame_interrupt_flag / _enable
    // ==========================================================
    // reset values and encodings
    localparam logic [7:0] RST_BYTE = 8'h00; // every register resets to zero
    localparam logic [1:0] MUX_STATIC = 2'h0; // single common
    localparam logic [1:0] MUX_THIRD = 2'h2; // three commons
    localparam logic [1:0] CS_SYSCLK = 2'h0; // system clock timing source
    localparam logic [1:0] LVL_V0 = 2'h0; // minimum drive voltage
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;
    localparam logic [2:0] SLOTS_FOUR = 3'h4; // static, 1/2 and 1/4 frame slots
    localparam logic [2:0] SLOTS_THREE = 3'h3; // 1/3 frame slots
    localparam logic [1:0] BMODE_M0 = 2'h0; // regulator with charge pump
    localparam logic [1:0] BMODE_M1 = 2'h1; // regulator without pump
    localparam logic [1:0] BMODE_M2 = 2'h2; // ladder with pump
    localparam logic [1:0] BMODE_M3 = 2'h3; // resistor ladder

    // all state of the controller
    typedef struct packed {
        logic [7:0] ctrl; // enable, sleep stop, source, commons
        logic write_error_flag; // write error, sticky
        logic [7:0] ps; // waveform, bias mode, prescale
        logic [7:0] regc; // regulator control
        logic flag; // frame interrupt flag
        logic ien; // frame interrupt enable
        logic [4:0][7:0] se; // segment pin enables
        logic [19:0][7:0] pix; // pixel data
        logic [3:0] pre_cnt; // prescale divider
        logic [1:0] slot; // slot index inside frame
        logic phase; // drive polarity
        logic odd_frame; // second frame of a pair
        logic window; // write window open
        logic [7:0] com_lvl; // common line levels
        logic [65:0] seg_lvl; // segment line levels
        logic [1:0] bmode; // decoded bias mode
        logic [2:0] trim; // contrast trim
        logic irq; // interrupt output
        logic active; // module running
        logic [31:0] prdata; // read data
        logic pready; // access phase answer
        logic pslverr; // unmapped access
    } lcf_state_t;
endpackage : lcf_pkg

// ### verilog/lcf_frame_ctrl.sv
// frame timing, pixel store, sleep handling and apb registers of the segment display controller
// ==========================================================
// Behaviour
// - frame begins at first common's leading edge
// - flag set when pixel fetch completes
// - two-frame interrupt only after complete pairs
// - two-frame multiplexed pixel write outside the window, or any pixel write in sleep, sets error bit five
// - no interrupt: per-frame waveform or static
// - control bit six selects stop in sleep
// - stop in sleep drives minimum voltage
// - running in sleep keeps showing pixels
// - sleep running needs non-system clock source
// - pixel data frozen while core sleeps
// - system clock source always halts in sleep
// - bias modes 0-2 have no contrast trim
// - flag and enable sit at bit six
// - bit seven enables any display drive
// - common count selects driven commons, resets 00
// - frame = source/(factor*(prescale+1))
// - phase per slot or per frame
`timescale 1ns/1ps
`default_nettype none
module lcf_frame_ctrl (
    input wire logic pclk, // 20 MHz bus clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic src_tick, // one-cycle pulse of the selected frame clock source
    input wire logic core_sleep, // core is asleep, level
    output logic [7:0] com_level, // two bits per common line
    output logic [65:0] seg_level, // two bits per segment line
    output logic [3:0] com_pin_en, // pins taken over as common drivers
    output logic [32:0] seg_pin_en, // pins used as segment drivers
    output logic [1:0] bias_mode, // decoded bias generation mode
    output logic [2:0] contrast_trim, // software contrast level
    output logic charge_pump_on, // charge pump running
    output logic [1:0] regulator_clk_sel, // regulator clock source
    output logic frame_irq, // frame interrupt request, level
    output logic module_active // display drive running
);
    // ==========================================================
    // helpers
    // frame slots per multiplex mode; the prescaler supplies the (prescale+1) term
    function automatic logic [2:0] slots_per_frame(input logic [1:0] mux);
        slots_per_frame = (mux == lcf_pkg::MUX_THIRD) ? lcf_pkg::SLOTS_THREE : lcf_pkg::SLOTS_FOUR;
    endfunction : slots_per_frame

    // common line that owns a slot; 1/2 mux spends two slots per common
    function automatic logic [1:0] com_of_slot(input logic [1:0] mux, input logic [1:0] slot);
        case (mux)
            lcf_pkg::MUX_STATIC: com_of_slot = 2'h0;
            2'h1: com_of_slot = {1'b0, slot[1]};
            default: com_of_slot = slot;
        endcase
    endfunction : com_of_slot

    // word inside a register range, index out
    function automatic logic in_range(input logic [11:0] a, input logic [11:0] base, input logic [4:0] n);
        logic [11:0] off;
        off = a - base;
        in_range = (a >= base) && (off[11:2] < {5'h00, n}) && (off[1:0] == 2'h0);
    endfunction : in_range

    function automatic logic [4:0] word_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        word_idx = off[6:2];
    endfunction : word_idx

    lcf_pkg::lcf_state_t s_q; // registered state
    lcf_pkg::lcf_state_t s_d; // next state

    // decoded control fields
    logic en; // module_enable
    logic sleep_stop_enable; // sleep_stop_enable
    logic [1:0] cs; // timing source
    logic [1:0] mux; // common_count_select
    logic waveform_type_select; // waveform_type_select, 1 = two-frame
    logic [3:0] lp; // frame_prescale
    logic halted; // frozen by sleep
    logic write_ok; // pixel writes allowed
    logic setup; // apb setup cycle
    logic wr_take; // write takes effect this edge
    logic [2:0] slots; // slots in current frame
    logic slot_tick; // prescaler wrap
    logic [1:0] slot_nx; // next slot index
    logic irq_ok; // frame interrupt permitted by mode
    logic flag_set; // frame interrupt event
    logic pix_err; // refused pixel write
    logic [31:0] rd; // read mux
    logic rd_err; // unmapped address
    logic [1:0] act_com; // common owning the slot
    logic [5:0] seg_i; // segment loop index
    logic [2:0] com_i; // common loop index
    logic pbit; // pixel bit under the active common

    assign en = s_q.ctrl[lcf_pkg::CTRL_EN];
    assign sleep_stop_enable = s_q.ctrl[lcf_pkg::CTRL_SLEEP_STOP_ENABLE];
    assign cs = s_q.ctrl[lcf_pkg::CTRL_CS_LSB +: 2];
    assign mux = s_q.ctrl[lcf_pkg::CTRL_MUX_LSB +: 2];
    assign waveform_type_select = s_q.ps[lcf_pkg::PS_WFT];
    assign lp = s_q.ps[3:0];
    // a set stop bit, or the system clock as source, halts the module in sleep
    assign halted = core_sleep && (sleep_stop_enable || cs == lcf_pkg::CS_SYSCLK);
    // two-frame multiplexed drive only takes new pixels inside the window; sleep freezes them
    assign write_ok = !core_sleep && (!(en && waveform_type_select && mux != lcf_pkg::MUX_STATIC) || s_q.window);
    assign setup = psel && !penable;
    assign wr_take = psel && penable && pwrite && s_q.pready;
    assign slots = slots_per_frame(mux);
    assign slot_tick = en && !halted && src_tick && (s_q.pre_cnt == lp);
    assign slot_nx = ({1'b0, s_q.slot} == slots - 3'h1) ? 2'h0 : s_q.slot + 2'h1;
    // per-frame waveform and static two-frame drive never interrupt
    assign irq_ok = waveform_type_select && mux != lcf_pkg::MUX_STATIC;
    assign act_com = com_of_slot(mux, s_q.slot);

    // ==========================================================
    // read mux
    always_comb begin
        rd = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            lcf_pkg::ADDR_CTRL: begin
                rd[7:0] = s_q.ctrl;
                rd[lcf_pkg::CTRL_WRITE_ERROR_FLAG] = s_q.write_error_flag;
            end
            lcf_pkg::ADDR_PS: begin
                rd[7:0] = s_q.ps;
                rd[lcf_pkg::PS_ACTIVE] = s_q.active;
                rd[lcf_pkg::PS_WA] = write_ok;
            end
            lcf_pkg::ADDR_REG: rd[7:0] = s_q.regc;
            lcf_pkg::ADDR_FLAG: rd[lcf_pkg::FLAG_BIT] = s_q.flag;
            lcf_pkg::ADDR_IEN: rd[lcf_pkg::FLAG_BIT] = s_q.ien;
            default: begin
                if (in_range(paddr, lcf_pkg::ADDR_SE_BASE, lcf_pkg::NUM_SE)) begin
                    rd[7:0] = s_q.se[word_idx(paddr, lcf_pkg::ADDR_SE_BASE)];
                end else if (in_range(paddr, lcf_pkg::ADDR_PIX_BASE, lcf_pkg::NUM_PIX)) begin
                    rd[7:0] = s_q.pix[word_idx(paddr, lcf_pkg::ADDR_PIX_BASE)];
                end else begin
                    rd_err = 1'b1; // unmapped: error, data zero
                end
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        flag_set = 1'b0;
        pix_err = 1'b0;
        pbit = 1'b0;
        // apb: answer in the cycle after setup, data captured at setup
        s_d.pready = setup;
        s_d.pslverr = setup && rd_err;
        if (setup) begin
            s_d.prdata = rd;
        end
        // register writes
        if (wr_take) begin
            case (paddr)
                lcf_pkg::ADDR_CTRL: s_d.ctrl = pwdata[7:0] & lcf_pkg::CTRL_WMASK;
                lcf_pkg::ADDR_PS: s_d.ps = pwdata[7:0] & lcf_pkg::PS_WMASK;
                lcf_pkg::ADDR_REG: s_d.regc = pwdata[7:0] & lcf_pkg::REG_WMASK;
                lcf_pkg::ADDR_IEN: s_d.ien = pwdata[lcf_pkg::FLAG_BIT];
                default: begin
                    if (in_range(paddr, lcf_pkg::ADDR_SE_BASE, lcf_pkg::NUM_SE)) begin
                        s_d.se[word_idx(paddr, lcf_pkg::ADDR_SE_BASE)] = pwdata[7:0];
                    end else if (in_range(paddr, lcf_pkg::ADDR_PIX_BASE, lcf_pkg::NUM_PIX)) begin
                        if (write_ok) begin
                            s_d.pix[word_idx(paddr, lcf_pkg::ADDR_PIX_BASE)] = pwdata[7:0];
                        end else begin
                            pix_err = 1'b1; // data dropped
                        end
                    end
                end
            endcase
            // write zero clears the sticky error
            if (paddr == lcf_pkg::ADDR_CTRL && !pwdata[lcf_pkg::CTRL_WRITE_ERROR_FLAG]) begin
                s_d.write_error_flag = 1'b0;
            end
            if (paddr == lcf_pkg::ADDR_FLAG && !pwdata[lcf_pkg::FLAG_BIT]) begin
                s_d.flag = 1'b0;
            end
        end

        // frame timing: prescaler, slots, frames
        if (!en) begin
            // disabled: timing restarts at the frame boundary
            s_d.pre_cnt = 4'h0;
            s_d.slot = 2'h0;
            s_d.phase = 1'b0;
            s_d.odd_frame = 1'b0;
            s_d.window = 1'b0;
        end else if (!halted && src_tick) begin
            s_d.pre_cnt = slot_tick ? 4'h0 : s_q.pre_cnt + 4'h1;
            if (slot_tick) begin
                s_d.slot = slot_nx;
                if (slot_nx == 2'h0) begin
                    // slot 0 is the first common's leading edge, the frame boundary
                    s_d.odd_frame = !s_q.odd_frame;
                end
                // per-frame waveform flips in every slot, two-frame only at boundaries
                s_d.phase = waveform_type_select ? (slot_nx == 2'h0 ? !s_q.odd_frame : s_q.odd_frame) : !s_q.phase;
                // last slot starts: every pixel of this frame has been fetched
                if ({1'b0, slot_nx} == slots - 3'h1 && irq_ok && s_q.odd_frame) begin
                    flag_set = 1'b1;
                    s_d.window = 1'b1;
                end
                // fetching for the new frame starts after its first slot: window shuts
                if (s_q.slot == 2'h0 && slot_nx != 2'h0) begin
                    s_d.window = 1'b0;
                end
            end
        end
        if (!irq_ok) begin
            s_d.window = 1'b0; // no window outside two-frame multiplexed drive
        end

        // sticky flags: a new event wins over a clear in the same cycle
        if (flag_set) begin
            s_d.flag = 1'b1;
        end
        if (pix_err) begin
            s_d.write_error_flag = 1'b1;
        end

        // line levels: minimum voltage when disabled or halted by sleep
        s_d.com_lvl = 8'h00;
        s_d.seg_lvl = 66'h0;
        if (en && !halted) begin
            for (com_i = 3'h0; com_i < 3'h4; com_i = com_i + 3'h1) begin
                if (com_i[1:0] <= mux) begin
                    if (com_i[1:0] == act_com) begin
                        s_d.com_lvl[com_i[1:0]*2 +: 2] = s_q.phase ? lcf_pkg::LVL_V0 : lcf_pkg::LVL_V3;
                    end else begin
                        s_d.com_lvl[com_i[1:0]*2 +: 2] = s_q.phase ? lcf_pkg::LVL_V2 : lcf_pkg::LVL_V1;
                    end
                end
            end
            for (seg_i = 6'h00; seg_i < 6'h21; seg_i = seg_i + 6'h01) begin
                pbit = s_q.pix[5'({3'h0, act_com} * lcf_pkg::PIX_PER_COM) + 5'({2'h0, seg_i[5:3]})][seg_i[2:0]];
                if (pbit) begin
                    s_d.seg_lvl[seg_i*2 +: 2] = s_q.phase ? lcf_pkg::LVL_V3 : lcf_pkg::LVL_V0;
                end else begin
                    s_d.seg_lvl[seg_i*2 +: 2] = s_q.phase ? lcf_pkg::LVL_V1 : lcf_pkg::LVL_V2;
                end
            end
        end

        // bias mode: regulator clock off means a ladder, pump picks M2 or M3
        if (s_q.regc[lcf_pkg::REG_CKSEL_LSB +: 2] == 2'h0) begin
            s_d.bmode = s_q.regc[lcf_pkg::REG_CHARGE_PUMP_ENABLE] ? lcf_pkg::BMODE_M2 : lcf_pkg::BMODE_M3;
        end else begin
            s_d.bmode = s_q.regc[lcf_pkg::REG_CHARGE_PUMP_ENABLE] ? lcf_pkg::BMODE_M0 : lcf_pkg::BMODE_M1;
        end
        // only the resistor ladder without pump (M3) offers software contrast
        s_d.trim = (s_d.bmode == lcf_pkg::BMODE_M3) ? s_q.regc[lcf_pkg::REG_BIAS_LSB +: 3] : 3'h0;
        s_d.irq = s_q.flag && s_q.ien;
        s_d.active = en && !halted;
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0; // every field resets to zero, commons to static
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign com_level = s_q.com_lvl;
    assign seg_level = s_q.seg_lvl;
    assign com_pin_en = {s_q.ctrl[1:0] == 2'h3, s_q.ctrl[1], s_q.ctrl[1:0] != 2'h0, 1'b1};
    assign seg_pin_en = {s_q.se[4][0], s_q.se[3], s_q.se[2], s_q.se[1], s_q.se[0]};
    assign bias_mode = s_q.bmode;
    assign contrast_trim = s_q.trim;
    assign charge_pump_on = s_q.regc[lcf_pkg::REG_CHARGE_PUMP_ENABLE];
    assign regulator_clk_sel = s_q.regc[lcf_pkg::REG_CKSEL_LSB +: 2];
    assign frame_irq = s_q.irq;
    assign module_active = s_q.active;
endmodule : lcf_frame_ctrl
`default_nettype wire

// ### test/lcf_frame_ctrl_properties.sv
// assertion checker for the segment display frame controller
`timescale 1ns/1ps
`default_nettype none
module lcf_frame_ctrl_properties (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [7:0] com_level, // common levels
    input wire logic [65:0] seg_level, // segment levels
    input wire logic [3:0] com_pin_en, // common pins taken
    input wire logic [32:0] seg_pin_en, // segment pins
    input wire logic [1:0] bias_mode, // decoded bias mode
    input wire logic [2:0] contrast_trim, // contrast level
    input wire logic charge_pump_on, // pump running
    input wire logic [1:0] regulator_clk_sel, // regulator clock
    input wire logic frame_irq, // frame interrupt
    input wire logic module_active // drive running
);
    // ==========================================================
    // helpers
    logic wr; // a write taking effect at this edge
    assign wr = psel && penable && pwrite && pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // bus answers: zero wait states, one cycle each
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
    a_unmapped_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
    // register bits reach the pins at the write edge
    a_mux_pins: assert property (wr && paddr == lcf_pkg::ADDR_CTRL
        |=> com_pin_en == ~(4'he << $past(pwdata[1:0]))) else $error("common pins wrong");
    a_seg_pins: assert property (wr && paddr == lcf_pkg::ADDR_SE_BASE
        |=> seg_pin_en[7:0] == $past(pwdata[7:0])) else $error("segment pins wrong");
    a_reg_bits: assert property (wr && paddr == lcf_pkg::ADDR_REG |=> regulator_clk_sel == $past(pwdata[1:0])
        && charge_pump_on == $past(pwdata[6])) else $error("regulator bits wrong");
    // contrast only exists with the resistor ladder
    a_trim_gate: assert property (bias_mode != lcf_pkg::BMODE_M3 |-> contrast_trim == 3'h0) else $error("trim");
    // clearing the enable stops the drive one edge after the write edge
    a_enable_gate: assert property (wr && paddr == lcf_pkg::ADDR_CTRL && !pwdata[7]
        |=> ##1 !module_active) else $error("still active after disable");
    // a stopped module holds every line at minimum voltage
    a_idle_quiet: assert property (!module_active [*3]
        |-> com_level == 8'h0 && seg_level == 66'h0) else $error("lines driven while stopped");
    c_irq: cover property (frame_irq);
    c_slverr: cover property (pready && pslverr);
    c_start: cover property (!module_active ##1 module_active);
endmodule : lcf_frame_ctrl_properties
bind lcf_frame_ctrl lcf_frame_ctrl_properties chk (.*);
`default_nettype wire

// ### test/lcf_panel_model.sv
// passive glass model: counts frames by the first common line
`timescale 1ns/1ps
`default_nettype none
module lcf_panel_model (
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, low
    input wire logic [1:0] com0, // first common level
    output int frames, // frames seen
    output int period // cycles of the last frame
);
    logic [1:0] prev; // level one cycle ago
    int cnt; // cycles since last frame start
    // a frame opens when the first common goes from an unselected to a selected level
    // a halt from an unselected level counts once more; periods are read only while running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 2'h0;
            cnt <= 1;
            frames <= 0;
            period <= 0;
        end else begin
            prev <= com0;
            cnt <= cnt + 1;
            if (com0[1] == com0[0] && prev[1] != prev[0]) begin
                frames <= frames + 1;
                period <= cnt;
                cnt <= 1;
            end
        end
    end
endmodule : lcf_panel_model
`default_nettype wire

// ### test/lcf_frame_ctrl_tb.sv
// self-checking bench for the segment display frame controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL %0t: got %h want %h", $time, a, b); end end
module lcf_frame_ctrl_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, src_tick = 0, core_sleep = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8f67;
    logic pready, pslverr, charge_pump_on, frame_irq, module_active;
    logic [7:0] com_level, pv[20], sv[5], rv[4], v;
    logic [65:0] seg_level;
    logic [3:0] com_pin_en;
    logic [32:0] seg_pin_en, q[$];
    logic [1:0] bias_mode, regulator_clk_sel, bm[4];
    logic [2:0] contrast_trim;
    int num_errors = 0, samples_checked = 0, frames, period, cyc = 0, t0;
    lcf_frame_ctrl uut (.*);
    lcf_panel_model panel (.pclk(pclk), .presetn(presetn), .com0(com_level[1:0]), .frames(frames),
        .period(period));
    // ==========================================================
    // clock, source ticks every fourth cycle, hang limit
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        src_tick <= (cyc % 4 == 3);
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    // scoreboard: oldest noted read result against the bus
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) `CHK({pslverr, prdata}, q.pop_front())
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [11:0] pix(input int i);
        return lcf_pkg::ADDR_PIX_BASE + 12'(4 * i);
    endfunction : pix
    // one apb transfer; a read may note its expected answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic c, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (c) q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0, 33'h0);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h0, 1'b1, {25'h0, e});
    endtask : rchk
    task automatic wait_irq;
        int n = 0;
        do @(posedge pclk); while (frame_irq !== 1'b1 && ++n < 3000);
        `CHK(n < 3000, 1'b1)
    endtask : wait_irq
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(lcf_pkg::ADDR_CTRL, 8'h00);
        rchk(lcf_pkg::ADDR_PS, 8'h10);
        apb(1'b0, 12'hffc, 8'h0, 1'b1, {1'b1, 32'h0});
        wr(lcf_pkg::ADDR_PS, 8'h83);
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            sv[i] = seed[7:0];
            wr(lcf_pkg::ADDR_SE_BASE + 12'(4 * i), sv[i]);
        end
        wr(lcf_pkg::ADDR_CTRL, 8'h07);
        @(posedge pclk);
        `CHK(seg_pin_en, {sv[4][0], sv[3], sv[2], sv[1], sv[0]})
        `CHK(com_pin_en, 4'hf)
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            pv[i] = seed[7:0];
            wr(pix(i), pv[i]);
            rchk(pix(i), pv[i]);
        end
        wr(lcf_pkg::ADDR_FLAG, 8'h00);
        wr(lcf_pkg::ADDR_IEN, 8'h40);
        wr(lcf_pkg::ADDR_CTRL, 8'h87);
        rchk(lcf_pkg::ADDR_IEN, 8'h40);
        // write inside the window, then outside it
        wait_irq();
        t0 = cyc;
        pv[1] = ~pv[1];
        wr(pix(1), pv[1]);
        rchk(pix(1), pv[1]);
        rchk(lcf_pkg::ADDR_FLAG, 8'h40);
        wr(lcf_pkg::ADDR_FLAG, 8'h00);
        repeat (50) @(posedge pclk);
        rchk(lcf_pkg::ADDR_PS, 8'ha3);
        wr(pix(2), ~pv[2]);
        rchk(pix(2), pv[2]);
        rchk(lcf_pkg::ADDR_CTRL, 8'ha7);
        wr(lcf_pkg::ADDR_CTRL, 8'h87);
        rchk(lcf_pkg::ADDR_CTRL, 8'h87);
        wait_irq();
        `CHK(cyc - t0, 128)
        // per-frame waveform, then static drive: no interrupt
        for (int k = 0; k < 2; k++) begin
            wr(lcf_pkg::ADDR_PS, k ? 8'h83 : 8'h03);
            wr(lcf_pkg::ADDR_CTRL, k ? 8'h84 : 8'h87);
            wr(lcf_pkg::ADDR_FLAG, 8'h00);
            repeat (300) @(posedge pclk);
            `CHK(frame_irq, 1'b0)
        end
        // frame period for four commons, three commons and a long prescale
        for (int k = 0; k < 3; k++) begin
            v = (k == 1) ? 8'h86 : 8'h87;
            wr(lcf_pkg::ADDR_PS, (k == 2) ? 8'h05 : 8'h00);
            wr(lcf_pkg::ADDR_CTRL, v);
            repeat (300) @(posedge pclk);
            `CHK(period, ((v[1:0] == 2'h2) ? 3 : 4) * ((k == 2) ? 6 : 1) * 4)
        end
        // every bias mode through the regulator byte
        rv = '{8'hb8, 8'h68, 8'h6d, 8'h2d};
        bm = '{2'h3, 2'h2, 2'h0, 2'h1};
        for (int k = 0; k < 4; k++) begin
            wr(lcf_pkg::ADDR_REG, rv[k]);
            repeat (2) @(posedge pclk);
            `CHK(bias_mode, bm[k])
            `CHK(contrast_trim, (bm[k] == 2'h3) ? rv[k][5:3] : 3'h0)
            rchk(lcf_pkg::ADDR_REG, rv[k] & 8'h7f);
        end
        // sleep: keep running, stop by the bit, stop on the system clock
        wr(lcf_pkg::ADDR_PS, 8'h80);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h87 : ((k == 1) ? 8'hc7 : 8'h83);
            wr(lcf_pkg::ADDR_CTRL, v);
            @(frames);
            t0 = frames;
            core_sleep <= 1'b1;
            repeat (40) @(posedge pclk);
            `CHK(module_active, k == 0)
            if (k != 0) `CHK({com_level, seg_level}, 74'h0)
            else `CHK(frames > t0, 1'b1)
            wr(pix(0), ~pv[0]);
            rchk(pix(0), pv[0]);
            core_sleep <= 1'b0;
            rchk(lcf_pkg::ADDR_CTRL, v | 8'h20);
        end
        summarize();
    end
endmodule : lcf_frame_ctrl_tb
`default_nettype wire
